// ### verilog/fru_params.svh
/*
  Constants of the single-operand file register unit: operation codes,
  widths and reset values.
  Assumes inclusion by bare name from the unit's files.
*/
`ifndef FRU_PARAMS_SVH
`define FRU_PARAMS_SVH

`define FRU_DATA_W 8
`define FRU_ADDR_W 5
`define FRU_OP_W 3

`define FRU_OP_NONE 3'h0
`define FRU_OP_CLRWD 3'h1
`define FRU_OP_CLEAR_FILE_INSTR 3'h2
`define FRU_OP_COMPLEMENT_FILE_INSTR 3'h3
`define FRU_OP_DECREMENT_FILE_INSTR 3'h4
`define FRU_OP_DECSZ 3'h5
`define FRU_OP_INCREMENT_FILE_INSTR 3'h6
`define FRU_OP_INCSZ 3'h7

`define FRU_ZERO_BYTE 8'h00
`define FRU_ONE_BYTE 8'h01
`define FRU_DEST_ACCUM 1'b0
`define FRU_DEST_FILE 1'b1

`define FRU_WDT_RESET 8'h00
`define FRU_PRESC_RESET 8'h00
`define FRU_ACCUM_RESET 8'h00
`define FRU_ZERO_RESET 1'b0
`define FRU_TO_N_RESET 1'b1
`define FRU_PD_N_RESET 1'b1

`endif

// ### verilog/fru_pkg.sv
/*
  Types of the single-operand file register unit.
  Assumes the params header is on the include path.
*/
package fru_pkg;
  typedef enum logic [0:0] {FRU_EXEC, FRU_FLUSH} fru_state_t;
endpackage : fru_pkg

// ### verilog/fru_unary_ops.sv
/*
  Execution unit for the single-operand instructions of a small 8-bit core:
  watchdog clear, clear file, complement, decrement, increment and the two
  skip-on-zero forms. Holds the accumulator, zero flag, the two active-low
  status bits, the watchdog counter and the shared prescaler.
  Assumes one instruction per sys_clk cycle from same-clock fetch logic, and
  that file read data for the presented address is valid in the same cycle.
*/
`timescale 1ns/100ps
`include "fru_params.svh"

module fru_unary_ops
  import fru_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Instruction in execute
  input wire logic instr_valid,
  input wire logic [`FRU_OP_W-1:0] instr_op,
  input wire logic [`FRU_ADDR_W-1:0] file_addr,
  input wire logic dest_bit,
  input wire logic [`FRU_DATA_W-1:0] file_rdata,
  // Timer side
  input wire logic prescaler_to_watchdog,
  input wire logic prescaler_tick,
  input wire logic watchdog_tick,
  input wire logic timeout_event,
  input wire logic sleep_event,
  // File write port
  output logic file_we_q,
  output logic [`FRU_ADDR_W-1:0] file_waddr_q,
  output logic [`FRU_DATA_W-1:0] file_wdata_q,
  // Core state
  output logic [`FRU_DATA_W-1:0] accum_q,
  output logic zero_flag_q,
  output logic timeout_status_n_q,
  output logic powerdown_status_n_q,
  output logic [`FRU_DATA_W-1:0] watchdog_counter_q,
  output logic [`FRU_DATA_W-1:0] prescaler_q,
  // Pipeline control
  output logic discard_next_q
);

  function automatic logic is_op(input logic [`FRU_OP_W-1:0] op, input logic [`FRU_OP_W-1:0] code);
    is_op = (op == code);
  endfunction : is_op

  fru_state_t state_q;
  fru_state_t state_d;

  // A discarded slot executes as a no-operation
  wire logic live = instr_valid && (state_q == FRU_EXEC);

  wire logic op_clrwd = live && is_op(instr_op, `FRU_OP_CLRWD);
  wire logic op_clear_file_instr = live && is_op(instr_op, `FRU_OP_CLEAR_FILE_INSTR);
  wire logic op_complement_file_instr = live && is_op(instr_op, `FRU_OP_COMPLEMENT_FILE_INSTR);
  wire logic op_decrement_file_instr = live && is_op(instr_op, `FRU_OP_DECREMENT_FILE_INSTR);
  wire logic op_decsz = live && is_op(instr_op, `FRU_OP_DECSZ);
  wire logic op_increment_file_instr = live && is_op(instr_op, `FRU_OP_INCREMENT_FILE_INSTR);
  wire logic op_incsz = live && is_op(instr_op, `FRU_OP_INCSZ);

  wire logic op_dec = op_decrement_file_instr || op_decsz;
  wire logic op_inc = op_increment_file_instr || op_incsz;
  wire logic op_routed = op_complement_file_instr || op_dec || op_inc;
  wire logic op_skip = op_decsz || op_incsz;
  wire logic op_flags = op_complement_file_instr || op_decrement_file_instr || op_increment_file_instr;

  wire logic [`FRU_DATA_W-1:0] comp_res = ~file_rdata;
  wire logic [`FRU_DATA_W-1:0] dec_res = file_rdata - `FRU_ONE_BYTE;
  wire logic [`FRU_DATA_W-1:0] inc_res = file_rdata + `FRU_ONE_BYTE;

  wire logic [`FRU_DATA_W-1:0] result =
    op_complement_file_instr ? comp_res :
    op_dec ? dec_res :
    op_inc ? inc_res : `FRU_ZERO_BYTE;
  wire logic result_zero = (result == `FRU_ZERO_BYTE);

  wire logic to_file = op_clear_file_instr || (op_routed && (dest_bit == `FRU_DEST_FILE));
  wire logic to_accum = op_routed && (dest_bit == `FRU_DEST_ACCUM);
  wire logic skip_now = op_skip && result_zero;

  // Clear-file always writes zero, so result already carries 00h for it
  wire logic [`FRU_DATA_W-1:0] wdata_d = op_clear_file_instr ? `FRU_ZERO_BYTE : result;

  // Skip forms leave the zero flag alone; clear-file forces it
  wire logic zero_d =
    op_clear_file_instr ? 1'b1 :
    op_flags ? result_zero : zero_flag_q;

  // The instruction's set wins over a same-cycle event that would clear
  wire logic to_n_d =
    op_clrwd ? 1'b1 :
    timeout_event ? 1'b0 : timeout_status_n_q;
  wire logic pd_n_d =
    op_clrwd ? 1'b1 :
    sleep_event ? 1'b0 : powerdown_status_n_q;

  wire logic [`FRU_DATA_W-1:0] wdt_d =
    op_clrwd ? `FRU_WDT_RESET :
    watchdog_tick ? watchdog_counter_q + `FRU_ONE_BYTE : watchdog_counter_q;

  // A prescaler owned by the general timer must not be disturbed
  wire logic presc_clr = op_clrwd && prescaler_to_watchdog;
  wire logic [`FRU_DATA_W-1:0] presc_d =
    presc_clr ? `FRU_PRESC_RESET :
    prescaler_tick ? prescaler_q + `FRU_ONE_BYTE : prescaler_q;

  wire logic [`FRU_DATA_W-1:0] accum_d = to_accum ? result : accum_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FRU_EXEC:
      begin
        if (skip_now)
          state_d = FRU_FLUSH;
      end
      FRU_FLUSH:
      begin
        state_d = FRU_EXEC;
      end
      default:
      begin
        state_d = FRU_EXEC;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= FRU_EXEC;
      discard_next_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      discard_next_q <= skip_now;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_we_q <= 1'b0;
      file_waddr_q <= '0;
      file_wdata_q <= `FRU_ZERO_BYTE;
    end
    else
    begin
      file_we_q <= to_file;
      file_waddr_q <= file_addr;
      file_wdata_q <= wdata_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accum_q <= `FRU_ACCUM_RESET;
      zero_flag_q <= `FRU_ZERO_RESET;
    end
    else
    begin
      accum_q <= accum_d;
      zero_flag_q <= zero_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timeout_status_n_q <= `FRU_TO_N_RESET;
      powerdown_status_n_q <= `FRU_PD_N_RESET;
      watchdog_counter_q <= `FRU_WDT_RESET;
      prescaler_q <= `FRU_PRESC_RESET;
    end
    else
    begin
      timeout_status_n_q <= to_n_d;
      powerdown_status_n_q <= pd_n_d;
      watchdog_counter_q <= wdt_d;
      prescaler_q <= presc_d;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_wdt_clear;
    op_clrwd |=> (watchdog_counter_q == `FRU_WDT_RESET);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

  property p_presc_owned;
    (op_clrwd && !prescaler_to_watchdog && !prescaler_tick) |=> (prescaler_q == $past(prescaler_q));
  endproperty
  a_presc_owned: assert property (p_presc_owned) else $error("timer prescaler disturbed");

  property p_presc_clear;
    (op_clrwd && prescaler_to_watchdog) |=> (prescaler_q == `FRU_PRESC_RESET);
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

  property p_status_set;
    op_clrwd |=> (timeout_status_n_q && powerdown_status_n_q);
  endproperty
  a_status_set: assert property (p_status_set) else $error("status bits not set");

  property p_clear_file_instr;
    op_clear_file_instr |=> (file_we_q && (file_wdata_q == `FRU_ZERO_BYTE) && zero_flag_q
      && (file_waddr_q == $past(file_addr)));
  endproperty
  a_clear_file_instr: assert property (p_clear_file_instr) else $error("clear file wrong");

  property p_complement_file_instr_accum;
    (op_complement_file_instr && (dest_bit == `FRU_DEST_ACCUM)) |=> (!file_we_q && (accum_q == ~$past(file_rdata)));
  endproperty
  a_complement_file_instr_accum: assert property (p_complement_file_instr_accum) else $error("complement to accumulator wrong");

  property p_complement_file_instr_file;
    (op_complement_file_instr && (dest_bit == `FRU_DEST_FILE)) |=>
      (file_we_q && (file_wdata_q == ~$past(file_rdata)) && (accum_q == $past(accum_q)));
  endproperty
  a_complement_file_instr_file: assert property (p_complement_file_instr_file) else $error("complement to file wrong");

  property p_dec_accum;
    (op_dec && (dest_bit == `FRU_DEST_ACCUM)) |=>
      (!file_we_q && (accum_q == $past(file_rdata) - `FRU_ONE_BYTE));
  endproperty
  a_dec_accum: assert property (p_dec_accum) else $error("decrement to accumulator wrong");

  property p_dec_file;
    (op_dec && (dest_bit == `FRU_DEST_FILE)) |=>
      (file_we_q && (file_wdata_q == $past(file_rdata) - `FRU_ONE_BYTE) && (accum_q == $past(accum_q)));
  endproperty
  a_dec_file: assert property (p_dec_file) else $error("decrement to file wrong");

  property p_skip_flags;
    op_skip |=> ($stable(zero_flag_q) && $stable(timeout_status_n_q));
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip form changed a flag");

  property p_skip_flush;
    (op_decsz && (file_rdata == `FRU_ONE_BYTE)) |=> (discard_next_q && !live) ##1 (state_q == FRU_EXEC);
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("decrement skip did not discard");

  property p_inc_accum;
    (op_increment_file_instr && (dest_bit == `FRU_DEST_ACCUM)) |=> (accum_q == $past(file_rdata) + `FRU_ONE_BYTE);
  endproperty
  a_inc_accum: assert property (p_inc_accum) else $error("increment to accumulator wrong");

  property p_inc_file;
    (op_inc && (dest_bit == `FRU_DEST_FILE)) |=>
      (file_we_q && (file_wdata_q == $past(file_rdata) + `FRU_ONE_BYTE) && (accum_q == $past(accum_q)));
  endproperty
  a_inc_file: assert property (p_inc_file) else $error("increment to file wrong");

  property p_incsz;
    op_incsz |=> (discard_next_q == ($past(file_rdata) == 8'hff)) && $stable(zero_flag_q);
  endproperty
  a_incsz: assert property (p_incsz) else $error("increment skip wrong");

  property p_zero_flag;
    op_flags |=> (zero_flag_q == ($past(result) == `FRU_ZERO_BYTE));
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_no_skip_nonzero;
    (op_skip && !result_zero) |=> !discard_next_q;
  endproperty
  a_no_skip_nonzero: assert property (p_no_skip_nonzero) else $error("skip on nonzero");

  property c_skip_taken;
    op_incsz && result_zero;
  endproperty
  cov_skip_taken: cover property (c_skip_taken);

  property c_decsz_back;
    op_decsz ##2 op_decsz;
  endproperty
  cov_decsz_back: cover property (c_decsz_back);

  property c_clrwd_presc;
    op_clrwd && prescaler_to_watchdog;
  endproperty
  cov_clrwd_presc: cover property (c_clrwd_presc);

  property c_dec_skip_taken;
    op_decsz && result_zero;
  endproperty
  cov_dec_skip_taken: cover property (c_dec_skip_taken);

endmodule : fru_unary_ops

// ### bench/test_file_register_unary_ops.sv
/*
  Self-checking bench for the single-operand file register unit.
  Assumes the unit's header and package are compiled before this file.
*/
`timescale 1ns/100ps
`include "fru_params.svh"

module test_file_register_unary_ops;
  // Operand table: zero and non-zero results, both destinations
  // Entry i sits at byte i; every accumulator result differs from the one before it
  localparam logic [47:0] VAL_TAB = 48'hff_3c_00_01_ff_a5;
  logic sys_clk, rst_n, instr_valid, dest_bit;
  logic prescaler_to_watchdog, prescaler_tick, watchdog_tick, timeout_event, sleep_event;
  logic [`FRU_OP_W-1:0] instr_op;
  logic [`FRU_ADDR_W-1:0] file_addr;
  logic [`FRU_DATA_W-1:0] file_rdata, file_wdata_q, accum_q, watchdog_counter_q, prescaler_q;
  logic [`FRU_ADDR_W-1:0] file_waddr_q;
  logic file_we_q, zero_flag_q, timeout_status_n_q, powerdown_status_n_q, discard_next_q;
  logic [7:0] exp_acc;
  int bad_count = 0;
  int n_tests = 0;

  fru_unary_ops dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
    .file_addr(file_addr), .dest_bit(dest_bit), .file_rdata(file_rdata),
    .prescaler_to_watchdog(prescaler_to_watchdog), .prescaler_tick(prescaler_tick),
    .watchdog_tick(watchdog_tick), .timeout_event(timeout_event), .sleep_event(sleep_event),
    .file_we_q(file_we_q), .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q), .accum_q(accum_q),
    .zero_flag_q(zero_flag_q), .timeout_status_n_q(timeout_status_n_q),
    .powerdown_status_n_q(powerdown_status_n_q), .watchdog_counter_q(watchdog_counter_q),
    .prescaler_q(prescaler_q), .discard_next_q(discard_next_q));

  task automatic conclude;
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Presents one instruction at a falling edge and holds it; results are read one cycle on
  task automatic exec(input logic [2:0] op, input logic d, input logic [7:0] r);
    instr_valid = 1'b1;
    instr_op = op;
    dest_bit = d;
    file_rdata = r;
    file_addr = file_addr + 5'h01;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : exec

  task automatic chk_wr(input logic we, input logic [7:0] data);
    chk("file_we", {7'h00, we}, {7'h00, file_we_q});
    if (we)
    begin
      chk("file_wdata", data, file_wdata_q);
      chk("file_waddr", {3'h0, file_addr}, {3'h0, file_waddr_q});
    end
  endtask : chk_wr

  task automatic t_reset;
    chk("accum", 8'h00, accum_q);
    chk("status", 8'h03, {6'h00, timeout_status_n_q, powerdown_status_n_q});
    chk("zero", 8'h00, {7'h00, zero_flag_q});
    chk("we_discard", 8'h00, {6'h00, file_we_q, discard_next_q});
  endtask : t_reset

  task automatic t_wdt;
    prescaler_to_watchdog = 1'b1;
    {watchdog_tick, prescaler_tick, timeout_event, sleep_event} = 4'hf;
    repeat (3) @(negedge sys_clk);
    // Events held into the clear, which must win over them
    {watchdog_tick, prescaler_tick, timeout_event, sleep_event} = 4'h3;
    chk("wdt_count", 8'h03, watchdog_counter_q);
    chk("status", 8'h00, {6'h00, timeout_status_n_q, powerdown_status_n_q});
    exec(`FRU_OP_CLRWD, 1'b0, 8'h00);
    chk("wdt_count", 8'h00, watchdog_counter_q);
    chk("prescaler", 8'h00, prescaler_q);
    chk("status", 8'h03, {6'h00, timeout_status_n_q, powerdown_status_n_q});
    // Prescaler lent to the general timer must survive the clear
    {instr_valid, timeout_event, sleep_event} = 3'h0;
    prescaler_to_watchdog = 1'b0;
    prescaler_tick = 1'b1;
    repeat (2) @(negedge sys_clk);
    prescaler_tick = 1'b0;
    exec(`FRU_OP_CLRWD, 1'b0, 8'h00);
    chk("prescaler", 8'h02, prescaler_q);
  endtask : t_wdt

  task automatic t_clear_file_instr;
    exec(`FRU_OP_CLEAR_FILE_INSTR, 1'b0, 8'h5a);
    chk_wr(1'b1, 8'h00);
    chk("zero", 8'h01, {7'h00, zero_flag_q});
    chk("accum", exp_acc, accum_q);
  endtask : t_clear_file_instr

  task automatic t_arith;
    logic [2:0] op;
    logic [7:0] r, res;
    logic d;
    for (int i = 0; i < 6; i++)
    begin
      op = (i < 2) ? `FRU_OP_COMPLEMENT_FILE_INSTR : (i < 4) ? `FRU_OP_DECREMENT_FILE_INSTR : `FRU_OP_INCREMENT_FILE_INSTR;
      r = VAL_TAB[8*i +: 8];
      d = i[0];
      res = (i < 2) ? ~r : (i < 4) ? r - 8'h01 : r + 8'h01;
      exec(op, d, r);
      if (d == `FRU_DEST_ACCUM)
        exp_acc = res;
      chk("accum", exp_acc, accum_q);
      chk_wr(d, res);
      chk("zero", {7'h00, res == 8'h00}, {7'h00, zero_flag_q});
    end
  endtask : t_arith

  task automatic t_skip;
    exec(`FRU_OP_COMPLEMENT_FILE_INSTR, 1'b1, 8'h5a);
    exec(`FRU_OP_DECSZ, 1'b1, 8'h01);
    chk_wr(1'b1, 8'h00);
    chk("discard", 8'h01, {7'h00, discard_next_q});
    chk("zero", 8'h00, {7'h00, zero_flag_q});
    // Offered in the discarded slot: must leave no trace
    exec(`FRU_OP_COMPLEMENT_FILE_INSTR, 1'b0, 8'h00);
    chk("accum", exp_acc, accum_q);
    chk_wr(1'b0, 8'h00);
    chk("discard", 8'h00, {7'h00, discard_next_q});
    exec(`FRU_OP_INCSZ, 1'b0, 8'hff);
    chk("accum", 8'h00, accum_q);
    chk("discard", 8'h01, {7'h00, discard_next_q});
    chk("zero", 8'h00, {7'h00, zero_flag_q});
    @(negedge sys_clk);
    exec(`FRU_OP_DECSZ, 1'b0, 8'h05);
    chk("accum", 8'h04, accum_q);
    chk("discard", 8'h00, {7'h00, discard_next_q});
    chk_wr(1'b0, 8'h00);
  endtask : t_skip

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Whole sequence needs well under 100 cycles
  initial
  begin
    #20000;
    bad_count++;
    conclude();
  end

  initial
  begin
    {instr_valid, dest_bit, prescaler_to_watchdog, prescaler_tick} = 4'h0;
    {watchdog_tick, timeout_event, sleep_event} = 3'h0;
    instr_op = `FRU_OP_NONE;
    file_addr = 5'h00;
    file_rdata = 8'h00;
    exp_acc = `FRU_ACCUM_RESET;
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_wdt();
    t_clear_file_instr();
    t_arith();
    t_skip();
    conclude();
  end
endmodule : test_file_register_unary_ops
